// file: inc/charge_accum_pkg.sv
// Package for the charge accumulator: register map, field positions, widths, timing.
// Assumes a 40 MHz clock and a plain address/strobe register port with 16-bit data.
package charge_accum_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int ACC_W   = 32;
	localparam int TALLY_W = 16;
	localparam int DATA_W  = 16;
	localparam int ADDR_W  = 7;
	localparam int SAMP_W  = 16;

	// ==========================================================
	// Register offsets
	// ==========================================================
	localparam logic [ADDR_W-1:0] ADDR_SYS_SETUP   = 7'h03;
	localparam logic [ADDR_W-1:0] ADDR_CONV_SETUP  = 7'h06;
	localparam logic [ADDR_W-1:0] ADDR_FAULT_THREE = 7'h26;
	localparam logic [ADDR_W-1:0] ADDR_FAULT_MASK  = 7'h29;
	localparam logic [ADDR_W-1:0] ADDR_OFFSET_COMP = 7'h2B;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_HI    = 7'h2C;
	localparam logic [ADDR_W-1:0] ADDR_TALLY       = 7'h2D;
	localparam logic [ADDR_W-1:0] ADDR_SNAP_HI     = 7'h2E;
	localparam logic [ADDR_W-1:0] ADDR_SNAP_LO     = 7'h2F;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT_LO    = 7'h30;
	localparam logic [ADDR_W-1:0] ADDR_STATUS      = 7'h31;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int BIT_PATH_ON     = 0;
	localparam int BIT_SLEEP_REQ   = 1;
	localparam int BIT_ACCUM_CLEAR = 0;
	localparam int BIT_FAULT_OVR   = 0;
	localparam int BIT_CLR_ON_READ = 0;
	localparam int BIT_WRAP_SEL    = 1;
	localparam int BIT_POS_OVF     = 2;
	localparam int BIT_NEG_OVF     = 3;
	localparam int BIT_TALLY_OVF   = 4;
	localparam int BIT_LIMIT_FLAG  = 5;
	localparam int BIT_WAKE_MASK   = 1;
	localparam int BIT_STS_SLEEP   = 0;
	localparam int BIT_STS_FROZEN  = 1;
	localparam int BIT_STS_READY   = 2;

	// ==========================================================
	// Reset values
	// ==========================================================
	localparam logic [DATA_W-1:0] RST_FAULT_MASK = 16'h0003;
	localparam logic [ACC_W-1:0]  RST_LIMIT      = 32'h7FFF_FFFF;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int CLK_HZ          = 40_000_000;
	localparam int SETTLE_NS       = 27_000;
	localparam int SETTLE_CYC      = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SETTLE_W        = 11;
	localparam int SLEEP_GAIN      = 256;

	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b001,
		MODE_SLEEP  = 3'b010,
		MODE_FROZEN = 3'b100
	} mode_t;

	typedef struct packed {
		logic              valid;
		logic              diag;
		logic [SAMP_W-1:0] value;
	} sample_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_t;

endpackage : charge_accum_pkg

// file: rtl/snap_store.sv
// Three-word snapshot memory holding tally, high and low charge words.
// Assumes one writer that loads all three words in one cycle; read data are registered.
`timescale 1ns/10ps
module snap_store (
	input  wire logic                                 clk_in,
	input  wire logic                                 srst_in,
	input  wire logic                                 load_in,
	input  wire logic [charge_accum_pkg::DATA_W-1:0]  tally_in,
	input  wire logic [charge_accum_pkg::DATA_W-1:0]  hi_in,
	input  wire logic [charge_accum_pkg::DATA_W-1:0]  lo_in,
	input  wire logic [1:0]                           sel_in,
	output logic      [charge_accum_pkg::DATA_W-1:0]  rdata_out
);
	logic [charge_accum_pkg::DATA_W-1:0] mem_q [3];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			mem_q[2] <= '0;
		end else if (load_in) begin
			mem_q[0] <= tally_in;
			mem_q[1] <= hi_in;
			mem_q[2] <= lo_in;
		end
	end

	// Reads see the contents after any load in the same cycle.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_out <= '0;
		end else if (load_in) begin
			case (sel_in)
				2'd0:    rdata_out <= tally_in;
				2'd1:    rdata_out <= hi_in;
				2'd2:    rdata_out <= lo_in;
				default: rdata_out <= '0;
			endcase
		end else begin
			case (sel_in)
				2'd0:    rdata_out <= mem_q[0];
				2'd1:    rdata_out <= mem_q[1];
				2'd2:    rdata_out <= mem_q[2];
				default: rdata_out <= '0;
			endcase
		end
	end
endmodule : snap_store

// file: rtl/charge_accumulator.sv
// Charge accumulator: integrates converter samples, counts them, offers coherent snapshots.
// Assumes samples arrive as one-cycle valid strobes on clk_in; the sleep input is a pin.
`timescale 1ns/10ps
module charge_accumulator (
	input  wire logic                                         clk_in,
	input  wire logic                                         srst_in,
	input  wire logic                                         reg_wr_in,
	input  wire logic                                         reg_rd_in,
	input  wire logic [charge_accum_pkg::ADDR_W-1:0]          reg_addr_in,
	input  wire logic [charge_accum_pkg::DATA_W-1:0]          reg_wdata_in,
	input  wire charge_accum_pkg::sample_t                    sample_in,
	input  wire logic                                         sleep_in,
	input  wire logic                                         cyclic_nonzero_in,
	output logic      [charge_accum_pkg::DATA_W-1:0]          reg_rdata_out,
	output logic                                              current_path_on_out,
	output logic                                              conv_allowed_out,
	output logic                                              fault_output,
	output logic                                              wake_out
);
	localparam int AW = charge_accum_pkg::ACC_W;
	localparam int TW = charge_accum_pkg::TALLY_W;
	localparam int DW = charge_accum_pkg::DATA_W;

	// ==========================================================
	// Functions
	// ==========================================================
	function automatic logic is_snap(input logic [charge_accum_pkg::ADDR_W-1:0] a);
		is_snap = (a == charge_accum_pkg::ADDR_TALLY) || (a == charge_accum_pkg::ADDR_SNAP_HI)
			|| (a == charge_accum_pkg::ADDR_SNAP_LO);
	endfunction : is_snap

	// Flag update: a hardware set wins over a host clear-by-writing-0.
	function automatic logic flag_next(input logic cur, input logic set, input logic wclr);
		flag_next = set | (cur & ~wclr);
	endfunction : flag_next

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	logic [1:0] sleep_sync_q;
	logic [1:0] cyc_sync_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sleep_sync_q <= '0;
			cyc_sync_q   <= '0;
		end else begin
			sleep_sync_q <= {sleep_sync_q[0], sleep_in};
			cyc_sync_q   <= {cyc_sync_q[0], cyclic_nonzero_in};
		end
	end
	logic sleep_s;
	logic cyc_s;
	assign sleep_s = sleep_sync_q[1];
	assign cyc_s   = cyc_sync_q[1];

	// ==========================================================
	// Register decode
	// ==========================================================
	logic wr_sys, wr_conv, wr_comp, wr_mask, wr_lim_hi, wr_lim_lo, wr_fault;
	logic rd_snap, wr_snap, other_acc;
	assign wr_sys    = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_SYS_SETUP;
	assign wr_conv   = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_CONV_SETUP;
	assign wr_comp   = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_OFFSET_COMP;
	assign wr_mask   = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_FAULT_MASK;
	assign wr_lim_hi = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_LIMIT_HI;
	assign wr_lim_lo = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_LIMIT_LO;
	assign wr_fault  = reg_wr_in && reg_addr_in == charge_accum_pkg::ADDR_FAULT_THREE;
	assign rd_snap   = reg_rd_in && is_snap(reg_addr_in);
	assign wr_snap   = reg_wr_in && is_snap(reg_addr_in);
	assign other_acc = (reg_wr_in || reg_rd_in) && !is_snap(reg_addr_in);

	logic accum_clear;
	assign accum_clear = wr_conv && reg_wdata_in[charge_accum_pkg::BIT_ACCUM_CLEAR];

	// ==========================================================
	// Configuration
	// ==========================================================
	logic          current_path_on_q;
	logic          clear_on_read_sel_q;
	logic          wrap_sel_q;
	logic [DW-1:0] fault_mask_q;
	logic [AW-1:0] charge_limit_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			current_path_on_q   <= 1'b0;
			clear_on_read_sel_q <= 1'b0;
			wrap_sel_q          <= 1'b0;
			fault_mask_q        <= charge_accum_pkg::RST_FAULT_MASK;
			charge_limit_q      <= charge_accum_pkg::RST_LIMIT;
		end else begin
			if (wr_sys)
				current_path_on_q <= reg_wdata_in[charge_accum_pkg::BIT_PATH_ON];
			if (wr_comp) begin
				clear_on_read_sel_q <= reg_wdata_in[charge_accum_pkg::BIT_CLR_ON_READ];
				wrap_sel_q          <= reg_wdata_in[charge_accum_pkg::BIT_WRAP_SEL];
			end
			if (wr_mask)
				fault_mask_q <= reg_wdata_in;
			if (wr_lim_hi)
				charge_limit_q[AW-1:DW] <= reg_wdata_in;
			if (wr_lim_lo)
				charge_limit_q[DW-1:0] <= reg_wdata_in;
		end
	end

	// Settling counter after enable; conversions may be requested once it expires.
	logic [charge_accum_pkg::SETTLE_W-1:0] settle_q;
	always_ff @(posedge clk_in) begin
		if (srst_in || !current_path_on_q)
			settle_q <= '0;
		else if (settle_q != charge_accum_pkg::SETTLE_W'(charge_accum_pkg::SETTLE_CYC))
			settle_q <= settle_q + 1'b1;
	end

	// ==========================================================
	// Mode
	// ==========================================================
	charge_accum_pkg::mode_t mode_q;
	logic                    wake_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			mode_q <= charge_accum_pkg::MODE_NORMAL;
		end else begin
			case (mode_q)
				charge_accum_pkg::MODE_NORMAL: if (sleep_s) begin
					mode_q <= charge_accum_pkg::MODE_SLEEP;
				end
				charge_accum_pkg::MODE_SLEEP: if (!sleep_s || wake_q) begin
					mode_q <= charge_accum_pkg::MODE_FROZEN;
				end
				charge_accum_pkg::MODE_FROZEN: if (accum_clear || (rd_snap && clear_on_read_sel_q)) begin
					mode_q <= charge_accum_pkg::MODE_NORMAL;
				end
				default: mode_q <= charge_accum_pkg::MODE_NORMAL;
			endcase
		end
	end

	// ==========================================================
	// Accumulator and tally
	// ==========================================================
	logic signed [AW-1:0] charge_accum_q;
	logic        [TW-1:0] sample_tally_q;
	logic signed [AW:0]   sum_wide;
	logic                 pos_ovf, neg_ovf, tally_ovf;
	logic                 take;
	logic                 rd_clear;
	logic signed [AW-1:0] sat_val;

	// Unit weight is one converter LSB; gain never scales the sum.
	assign sum_wide = {charge_accum_q[AW-1], charge_accum_q}
		+ (AW+1)'(signed'(sample_in.value));
	assign pos_ovf  = take && !sum_wide[AW] && sum_wide[AW-1];
	assign neg_ovf  = take && sum_wide[AW] && !sum_wide[AW-1];
	assign tally_ovf = take && (&sample_tally_q);
	// Diagnostic samples take the same path as shunt samples.
	assign take = sample_in.valid && current_path_on_q
		&& (mode_q == charge_accum_pkg::MODE_NORMAL
		|| (mode_q == charge_accum_pkg::MODE_SLEEP && cyc_s));
	assign rd_clear = rd_snap && clear_on_read_sel_q;
	assign sat_val  = pos_ovf ? {1'b0, {(AW-1){1'b1}}} : {1'b1, {(AW-1){1'b0}}};

	always_ff @(posedge clk_in) begin
		if (srst_in || accum_clear || rd_clear) begin
			charge_accum_q <= '0;
		end else if (take) begin
			if ((pos_ovf || neg_ovf) && !wrap_sel_q)
				charge_accum_q <= sat_val;
			else
				charge_accum_q <= sum_wide[AW-1:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in || accum_clear || rd_clear)
			sample_tally_q <= '0;
		else if (take)
			sample_tally_q <= sample_tally_q + 1'b1;
	end

	// ==========================================================
	// Flags, fault and wake
	// ==========================================================
	logic pos_flag_q, neg_flag_q, tally_flag_q, limit_flag_q, fault_q;
	logic limit_cross;
	assign limit_cross = take && mode_q == charge_accum_pkg::MODE_SLEEP
		&& $signed(sum_wide[AW-1:0]) > $signed(charge_limit_q);

	logic wclr_p, wclr_n, wclr_t, wclr_l, wclr_f;
	assign wclr_p = wr_comp && !reg_wdata_in[charge_accum_pkg::BIT_POS_OVF];
	assign wclr_n = wr_comp && !reg_wdata_in[charge_accum_pkg::BIT_NEG_OVF];
	assign wclr_t = wr_comp && !reg_wdata_in[charge_accum_pkg::BIT_TALLY_OVF];
	assign wclr_l = wr_comp && !reg_wdata_in[charge_accum_pkg::BIT_LIMIT_FLAG];
	assign wclr_f = wr_fault && !reg_wdata_in[charge_accum_pkg::BIT_FAULT_OVR];

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pos_flag_q   <= 1'b0;
			neg_flag_q   <= 1'b0;
			tally_flag_q <= 1'b0;
			limit_flag_q <= 1'b0;
			fault_q      <= 1'b0;
		end else begin
			pos_flag_q   <= flag_next(pos_flag_q, pos_ovf, wclr_p);
			neg_flag_q   <= flag_next(neg_flag_q, neg_ovf, wclr_n);
			tally_flag_q <= flag_next(tally_flag_q, tally_ovf, wclr_t);
			limit_flag_q <= flag_next(limit_flag_q, limit_cross, wclr_l);
			fault_q      <= flag_next(fault_q,
				pos_ovf | neg_ovf | tally_ovf | limit_cross, wclr_f);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in)
			wake_q <= 1'b0;
		else
			wake_q <= limit_cross && fault_mask_q[charge_accum_pkg::BIT_WAKE_MASK];
	end

	// ==========================================================
	// Snapshot control
	// ==========================================================
	logic armed_q;
	always_ff @(posedge clk_in) begin
		if (srst_in)
			armed_q <= 1'b1;
		else if (other_acc || wr_snap)
			armed_q <= 1'b1;
		else if (rd_snap)
			armed_q <= 1'b0;
	end

	logic          snap_load;
	logic [DW-1:0] ld_tally, ld_hi, ld_lo;
	assign snap_load = accum_clear || (rd_snap && armed_q);
	assign ld_tally  = accum_clear ? '0 : DW'(sample_tally_q);
	assign ld_hi     = accum_clear ? '0 : charge_accum_q[AW-1:DW];
	assign ld_lo     = accum_clear ? '0 : charge_accum_q[DW-1:0];

	logic [1:0]    snap_sel;
	logic [DW-1:0] snap_rdata;
	assign snap_sel = 2'(reg_addr_in - charge_accum_pkg::ADDR_TALLY);

	snap_store u_snap (
		.clk_in    (clk_in),
		.srst_in   (srst_in),
		.load_in   (snap_load),
		.tally_in  (ld_tally),
		.hi_in     (ld_hi),
		.lo_in     (ld_lo),
		.sel_in    (snap_sel),
		.rdata_out (snap_rdata)
	);

	// ==========================================================
	// Read port
	// ==========================================================
	logic          rd_snap_q;
	logic [DW-1:0] rd_reg_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rd_snap_q <= 1'b0;
			rd_reg_q  <= '0;
		end else begin
			rd_snap_q <= rd_snap;
			rd_reg_q  <= '0;
			if (reg_rd_in) begin
				case (reg_addr_in)
					charge_accum_pkg::ADDR_SYS_SETUP:   rd_reg_q <= DW'(current_path_on_q);
					charge_accum_pkg::ADDR_FAULT_THREE: rd_reg_q <= DW'(fault_q);
					charge_accum_pkg::ADDR_FAULT_MASK:  rd_reg_q <= fault_mask_q;
					charge_accum_pkg::ADDR_OFFSET_COMP: rd_reg_q <= DW'({limit_flag_q,
						tally_flag_q, neg_flag_q, pos_flag_q, wrap_sel_q, clear_on_read_sel_q});
					charge_accum_pkg::ADDR_LIMIT_HI:    rd_reg_q <= charge_limit_q[AW-1:DW];
					charge_accum_pkg::ADDR_LIMIT_LO:    rd_reg_q <= charge_limit_q[DW-1:0];
					charge_accum_pkg::ADDR_STATUS:      rd_reg_q <= DW'({
						settle_q == charge_accum_pkg::SETTLE_W'(charge_accum_pkg::SETTLE_CYC),
						mode_q == charge_accum_pkg::MODE_FROZEN,
						mode_q == charge_accum_pkg::MODE_SLEEP});
					default:                            rd_reg_q <= '0;
				endcase
			end
		end
	end
	assign reg_rdata_out = rd_snap_q ? snap_rdata : rd_reg_q;

	// ==========================================================
	// Outputs
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			current_path_on_out <= 1'b0;
			conv_allowed_out    <= 1'b0;
			fault_output        <= 1'b0;
			wake_out            <= 1'b0;
		end else begin
			current_path_on_out <= current_path_on_q;
			conv_allowed_out    <= current_path_on_q && settle_q ==
				charge_accum_pkg::SETTLE_W'(charge_accum_pkg::SETTLE_CYC);
			fault_output        <= fault_q && fault_mask_q[charge_accum_pkg::BIT_FAULT_OVR];
			wake_out            <= wake_q;
		end
	end

	// ==========================================================
	// Checks
	// ==========================================================
	chk_clear_zeroes: assert property (@(posedge clk_in) disable iff (srst_in)
		accum_clear |=> charge_accum_q == 0 && sample_tally_q == 0)
		else $error("clear did not zero sum and tally");
	chk_tally_step: assert property (@(posedge clk_in) disable iff (srst_in)
		take && !accum_clear && !rd_clear |=> sample_tally_q == $past(sample_tally_q) + 1'b1)
		else $error("tally did not step on a sample");
	chk_snap_hold: assert property (@(posedge clk_in) disable iff (srst_in)
		rd_snap && !armed_q |-> !snap_load)
		else $error("snapshot refreshed on repeated read");
	chk_clamp_mode: assert property (@(posedge clk_in) disable iff (srst_in)
		pos_ovf && !wrap_sel_q && !accum_clear && !rd_clear
		|=> charge_accum_q == {1'b0, {(AW-1){1'b1}}})
		else $error("sum did not clamp");
	chk_pos_flag: assert property (@(posedge clk_in) disable iff (srst_in)
		pos_ovf |=> pos_flag_q)
		else $error("positive overflow flag missed");
	chk_tally_flag: assert property (@(posedge clk_in) disable iff (srst_in)
		tally_ovf |=> tally_flag_q)
		else $error("tally overflow flag missed");
	chk_fault_out: assert property (@(posedge clk_in) disable iff (srst_in)
		(pos_ovf || tally_ovf) && fault_mask_q[charge_accum_pkg::BIT_FAULT_OVR]
		&& !wr_mask |=> ##1 fault_output)
		else $error("fault output not raised");
	chk_frozen_hold: assert property (@(posedge clk_in) disable iff (srst_in)
		mode_q == charge_accum_pkg::MODE_FROZEN && !accum_clear && !rd_clear
		|=> $stable(charge_accum_q))
		else $error("sum moved while frozen");
	chk_clr_on_read: assert property (@(posedge clk_in) disable iff (srst_in)
		rd_snap && clear_on_read_sel_q |=> charge_accum_q == 0)
		else $error("clear on read failed");
endmodule : charge_accumulator

// file: test/conv_source.sv
// Converter model: hands one sample per cycle to the accumulator.
// Assumes the caller runs send from the bench after reset.
`timescale 1ns/10ps
module conv_source (
	input  wire logic                 clk_in,
	output charge_accum_pkg::sample_t sample_out
);
	initial sample_out = '0;

	// Outside a burst the value lines show the inverse so a stale value is never taken.
	task automatic send(input logic [15:0] v, input logic dg, input int n);
		repeat (n) begin
			@(posedge clk_in);
			sample_out <= '{1'b1, dg, v};
		end
		@(posedge clk_in);
		sample_out <= '{1'b0, 1'b0, ~v};
	endtask : send
endmodule : conv_source

// file: test/test_charge_accumulator.sv
// Testbench for the charge accumulator: register tasks and directed sequences.
// Assumes conv_source as the converter and a 40 MHz clock.
`timescale 1ns/10ps
module test_charge_accumulator;
	logic                      clk_in = 1'b0;
	logic                      srst_in = 1'b1;
	logic                      wr = 1'b0;
	logic                      rd = 1'b0;
	logic [6:0]                ad = 7'h0;
	logic [15:0]               wd = 16'h0;
	logic                      slp = 1'b0;
	logic                      cyc = 1'b0;
	logic [15:0]               rdata;
	logic                      path_on;
	logic                      conv_ok;
	logic                      flt;
	logic                      wake;
	charge_accum_pkg::sample_t smp;
	int                        n_fail = 0;
	int                        check_count = 0;
	int                        wakes = 0;

	always #12.5 clk_in = ~clk_in;

	charge_accumulator i_dut (.clk_in(clk_in), .srst_in(srst_in), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_addr_in(ad), .reg_wdata_in(wd), .sample_in(smp),
		.sleep_in(slp), .cyclic_nonzero_in(cyc), .reg_rdata_out(rdata),
		.current_path_on_out(path_on), .conv_allowed_out(conv_ok),
		.fault_output(flt), .wake_out(wake));
	conv_source i_src (.clk_in(clk_in), .sample_out(smp));

	always @(posedge clk_in) if (wake === 1'b1) wakes <= wakes + 1;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wrr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk_in);
		wr <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask : wrr

	task automatic rdr(input logic [6:0] a, output logic [15:0] d);
		@(posedge clk_in);
		rd <= 1'b1;
		ad <= a;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rdr

	task automatic rchk(input string nm, input logic [6:0] a, input logic [15:0] e);
		logic [15:0] x;
		rdr(a, x);
		chk(nm, 32'(x), 32'(e));
	endtask : rchk

	task automatic other();
		logic [15:0] x;
		rdr(charge_accum_pkg::ADDR_STATUS, x);
	endtask : other

	// Reads tally, high and low words; charge is rebuilt high word first.
	task automatic snap(input logic [15:0] t, input logic [31:0] q);
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] c;
		rdr(charge_accum_pkg::ADDR_TALLY, a);
		rdr(charge_accum_pkg::ADDR_SNAP_HI, b);
		rdr(charge_accum_pkg::ADDR_SNAP_LO, c);
		chk("tally", 32'(a), 32'(t));
		chk("charge", {b, c}, q);
	endtask : snap

	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	initial begin
		repeat (90000) @(posedge clk_in);
		n_fail++;
		close_out();
	end

	initial begin
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		i_src.send(16'h0005, 1'b0, 1);
		wrr(charge_accum_pkg::ADDR_SYS_SETUP, 16'h0001);
		@(posedge clk_in);
		#1 chk("allow", 32'(conv_ok), 32'h0);
		chk("path", 32'(path_on), 32'h1);
		wrr(charge_accum_pkg::ADDR_CONV_SETUP, 16'h0001);
		i_src.send(16'h0005, 1'b0, 1);
		i_src.send(16'hFFFD, 1'b0, 1);
		i_src.send(16'h000A, 1'b1, 1);
		snap(16'h0003, 32'h0000_000C);
		i_src.send(16'h0007, 1'b0, 1);
		snap(16'h0003, 32'h0000_000C);
		other();
		snap(16'h0004, 32'h0000_0013);
		i_src.send(16'h0001, 1'b0, 1);
		wrr(charge_accum_pkg::ADDR_TALLY, 16'h0000);
		snap(16'h0005, 32'h0000_0014);
		wrr(charge_accum_pkg::ADDR_CONV_SETUP, 16'h0001);
		snap(16'h0000, 32'h0000_0000);
		wrr(charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0003);
		i_src.send(16'h0004, 1'b0, 2);
		snap(16'h0002, 32'h0000_0008);
		other();
		snap(16'h0000, 32'h0000_0000);
		wrr(charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0000);
		i_src.send(16'h7FFF, 1'b0, 65540);
		repeat (2) @(posedge clk_in);
		#1 chk("fault", 32'(flt), 32'h1);
		chk("allow", 32'(conv_ok), 32'h1);
		rchk("flags", charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0014);
		rchk("fstat", charge_accum_pkg::ADDR_FAULT_THREE, 16'h0001);
		snap(16'h0004, 32'h7FFF_FFFF);
		wrr(charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0002);
		rchk("flags", charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0002);
		i_src.send(16'h0001, 1'b0, 1);
		i_src.send(16'h8000, 1'b0, 1);
		other();
		snap(16'h0006, 32'h7FFF_8000);
		rchk("flags", charge_accum_pkg::ADDR_OFFSET_COMP, 16'h000E);
		wrr(charge_accum_pkg::ADDR_FAULT_THREE, 16'h0000);
		repeat (2) @(posedge clk_in);
		#1 chk("fault", 32'(flt), 32'h0);
		wrr(charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0002);
		wrr(charge_accum_pkg::ADDR_CONV_SETUP, 16'h0001);
		wrr(charge_accum_pkg::ADDR_LIMIT_HI, 16'h0000);
		wrr(charge_accum_pkg::ADDR_LIMIT_LO, 16'h0010);
		slp <= 1'b1;
		repeat (4) @(posedge clk_in);
		i_src.send(16'h0040, 1'b0, 1);
		cyc <= 1'b1;
		repeat (4) @(posedge clk_in);
		i_src.send(16'h0008, 1'b0, 1);
		i_src.send(16'h0009, 1'b0, 1);
		repeat (4) @(posedge clk_in);
		chk("wake", 32'(wakes), 32'h1);
		slp <= 1'b0;
		repeat (4) @(posedge clk_in);
		i_src.send(16'h0005, 1'b0, 1);
		other();
		snap(16'h0002, 32'h0000_0011);
		rchk("flags", charge_accum_pkg::ADDR_OFFSET_COMP, 16'h0022);
		rchk("fstat", charge_accum_pkg::ADDR_FAULT_THREE, 16'h0001);
		wrr(charge_accum_pkg::ADDR_CONV_SETUP, 16'h0001);
		i_src.send(16'h0003, 1'b0, 1);
		other();
		snap(16'h0001, 32'h0000_0003);
		close_out();
	end
endmodule : test_charge_accumulator
